// File: design/mie_defines.vh
/*
  constants for the instruction execute block: register byte addresses,
  field positions, opcodes, flag bit positions, reset values.
  assumes inclusion by bare name from the design file.
*/
`ifndef MIE_DEFINES_VH
`define MIE_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define MIE_A_INSTR 12'h000
`define MIE_A_WREG 12'h004
`define MIE_A_STAT 12'h008
`define MIE_A_PC 12'h00C
`define MIE_A_WDOG 12'h010
`define MIE_A_IRQ 12'h014
`define MIE_A_STACK 12'h018
`define MIE_A_MEM 12'h100

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define MIE_F_OP 4:0
`define MIE_F_IMM 15:8
`define MIE_F_ADDR_LSB 16

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define MIE_S_C 0
`define MIE_S_AC 1
`define MIE_S_Z 2
`define MIE_S_OV 3
`define MIE_S_PDF 4
`define MIE_S_TO 5
`define MIE_S_GIE 6
`define MIE_S_HALT 7
`define MIE_S_BUSY 8
`define MIE_STAT_WMASK 8'h6F

// ----------------------------------------
// irq control bits
// ----------------------------------------
`define MIE_I_PEND 0
`define MIE_I_WAKE 1

// ----------------------------------------
// opcodes
// ----------------------------------------
`define MIE_OP_NOP 5'h00
`define MIE_OP_INVERT_TO_REGISTER_OP 5'h01
`define MIE_OP_BCD 5'h02
`define MIE_OP_INC 5'h03
`define MIE_OP_DEC 5'h04
`define MIE_OP_INCA 5'h05
`define MIE_OP_DECA 5'h06
`define MIE_OP_HALT 5'h07
`define MIE_OP_JMP 5'h08
`define MIE_OP_MOVAM 5'h09
`define MIE_OP_MOVAX 5'h0A
`define MIE_OP_MOVMA 5'h0B
`define MIE_OP_ORAM 5'h0C
`define MIE_OP_ORAX 5'h0D
`define MIE_OP_ORM 5'h0E
`define MIE_OP_RET 5'h0F
`define MIE_OP_RETAX 5'h10
`define MIE_OP_INTERRUPT_RETURN_OP 5'h11
`define MIE_OP_RL 5'h12
`define MIE_OP_RLA 5'h13
`define MIE_OP_RLC 5'h14
`define MIE_OP_RLCA 5'h15
`define MIE_OP_RR 5'h16
`define MIE_OP_RRA 5'h17
`define MIE_OP_RRC 5'h18
`define MIE_OP_RRCA 5'h19
`define MIE_OP_SUBB 5'h1A
`define MIE_OP_SUBBM 5'h1B

// ----------------------------------------
// arithmetic constants and reset values
// ----------------------------------------
`define MIE_NIB_MAX 4'h9
`define MIE_ADJ_LO 8'h06
`define MIE_ADJ_HI 8'h60
`define MIE_ZERO8 8'h00
`define MIE_ONE8 8'h01
`define MIE_INT_VEC 12'h004

`endif

// File: design/mie_core.v
/*
  instruction execute unit for an 8-bit core: working register, status
  flags, small data memory, program counter, return stack and watchdog,
  reached over an ahb-lite slave port.
  assumes one ahb-lite master on hclk; hsel/htrans/haddr come from logic
  on the same clock, so no synchronisers.
*/
// Contract
// - invert-to-register puts ~mem in working register, memory kept, only zero flag
// - bcd adjust adds 6 to low nibble if above 9 or half carry
// - bcd adjust adds 6 to high nibble if above 9 or carry
// - bcd adjust writes working register plus 00/06/60/66 to memory
// - bcd adjust changes only carry, which marks decimal overflow
// - in-place increment/decrement writes memory back, only zero flag
// - register-target increment/decrement writes working register, only zero flag
// - halt stops execution, keeps state, clears watchdog and prescaler
// - halt sets power down flag, clears timeout flag, nothing else
// - jump loads program counter, two cycles with a dummy, no flags
// - moves copy memory/immediate/register without flag change
// - no-op only advances execution
// - or with memory or immediate, result to register or memory, zero flag
// - return pops stack into program counter, no flags
// - return-with-literal pops stack and loads immediate to working register
// - interrupt return pops stack and sets global interrupt gate
// - pending interrupt at interrupt return is serviced first
// - rotate left moves bit 7 into bit 0, no flags
// - rotate left through carry moves bit 7 into carry and carry into bit 0
// - rotate right moves bit 0 into bit 7, no flags
// - rotate right through carry moves bit 0 into carry and carry into bit 7
// - subtract with borrow sets carry, overflow, zero, half carry
`include "mie_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module mie_core #(
  parameter MEM_DEPTH = 16,
  parameter MEM_AW = 4,
  parameter STACK_DEPTH = 8,
  parameter STACK_AW = 3,
  parameter PC_W = 12,
  parameter PRE_W = 8,
  parameter WDOG_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire core_clk_en
);

  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_DUMMY = 2'd2;
  localparam ST_HALT = 2'd3;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [1:0] state_r;
  reg [31:0] instr_r;
  reg [7:0] wreg_r;
  reg carry_r, half_carry_flag_r, zero_r, signed_range_flag_r;
  reg power_down_flag_r, watchdog_timeout_flag_r, global_interrupt_gate_r;
  reg irq_pend_r;
  reg [PC_W-1:0] pc_r;
  reg [PC_W-1:0] stack_r [0:STACK_DEPTH-1];
  reg [STACK_AW:0] sp_r;
  reg [7:0] mem_r [0:MEM_DEPTH-1];
  reg [PRE_W-1:0] pre_r;
  reg [WDOG_W-1:0] watchdog_counter_r;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  reg dp_act_r, dp_write_r, rd_wait_r;
  reg [11:0] dp_addr_r;
  wire busy = (state_r == ST_EXEC) || (state_r == ST_DUMMY);
  wire ap_take = hsel & htrans[1] & hready;
  // writes wait while an instruction runs so bus and core never write together
  wire wr_stall = dp_act_r & dp_write_r & busy;
  wire rd_stall = dp_act_r & ~dp_write_r & ~rd_wait_r;
  assign hreadyout = ~(wr_stall | rd_stall);
  assign hresp = 1'b0;
  wire wr_go = dp_act_r & dp_write_r & ~busy;
  wire mem_hit = (dp_addr_r[11:8] == `MIE_A_MEM >> 8) && (dp_addr_r[7:2] < MEM_DEPTH);
  wire [MEM_AW-1:0] bus_midx = dp_addr_r[MEM_AW+1:2];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      rd_wait_r <= 1'b0;
    end else begin
      if (hreadyout) begin
        dp_act_r <= ap_take;
        dp_write_r <= hwrite;
        dp_addr_r <= {haddr[11:2], 2'b00};
        rd_wait_r <= 1'b0;
      end else if (rd_stall) begin
        rd_wait_r <= 1'b1;
      end
    end
  end

  wire [8:0] stat_word = {busy, state_r == ST_HALT, global_interrupt_gate_r, watchdog_timeout_flag_r,
                          power_down_flag_r, signed_range_flag_r, zero_r, half_carry_flag_r, carry_r};

  // read data is captured in the wait cycle, after any earlier write has landed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_stall) begin
      if (mem_hit)
        hrdata <= {24'h000000, mem_r[bus_midx]};
      else begin
        case (dp_addr_r)
          `MIE_A_INSTR: hrdata <= instr_r;
          `MIE_A_WREG: hrdata <= {24'h000000, wreg_r};
          `MIE_A_STAT: hrdata <= {23'h000000, stat_word};
          `MIE_A_PC: hrdata <= {{(32-PC_W){1'b0}}, pc_r};
          `MIE_A_WDOG: hrdata <= {{(32-WDOG_W){1'b0}}, watchdog_counter_r};
          `MIE_A_IRQ: hrdata <= {31'h00000000, irq_pend_r};
          `MIE_A_STACK: hrdata <= {{(31-STACK_AW){1'b0}}, sp_r};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  wire wr_instr = wr_go && dp_addr_r == `MIE_A_INSTR && state_r == ST_IDLE;
  wire wr_wreg = wr_go && dp_addr_r == `MIE_A_WREG;
  wire wr_stat = wr_go && dp_addr_r == `MIE_A_STAT;
  wire wr_pc = wr_go && dp_addr_r == `MIE_A_PC;
  wire wr_irq = wr_go && dp_addr_r == `MIE_A_IRQ;
  wire wr_push = wr_go && dp_addr_r == `MIE_A_STACK;
  wire wr_mem = wr_go && mem_hit;

  // ----------------------------------------
  // instruction decode and datapath
  // ----------------------------------------
  wire [4:0] op = instr_r[`MIE_F_OP];
  wire [7:0] imm = instr_r[`MIE_F_IMM];
  wire [PC_W-1:0] jaddr = instr_r[`MIE_F_ADDR_LSB+PC_W-1:`MIE_F_ADDR_LSB];
  wire [MEM_AW-1:0] midx = instr_r[`MIE_F_ADDR_LSB+MEM_AW-1:`MIE_F_ADDR_LSB];
  wire [7:0] mval = mem_r[midx];
  wire stk_empty = (sp_r == {(STACK_AW+1){1'b0}});
  wire [STACK_AW:0] sp_dec = sp_r - 1'b1;
  wire [PC_W-1:0] stk_top = stack_r[sp_dec[STACK_AW-1:0]];

  // bcd adjust offsets
  wire adj_lo = (wreg_r[3:0] > `MIE_NIB_MAX) | half_carry_flag_r;
  wire adj_hi = (wreg_r[7:4] > `MIE_NIB_MAX) | carry_r;
  wire [7:0] bcd_off = (adj_lo ? `MIE_ADJ_LO : `MIE_ZERO8) | (adj_hi ? `MIE_ADJ_HI : `MIE_ZERO8);
  wire [7:0] bcd_res = wreg_r + bcd_off;

  // subtract with borrow: acc - m - ~c
  wire borrow_in = ~carry_r;
  wire [8:0] sub_full = {1'b0, wreg_r} - {1'b0, mval} - {8'h00, borrow_in};
  wire [4:0] sub_nib = {1'b0, wreg_r[3:0]} - {1'b0, mval[3:0]} - {4'h0, borrow_in};
  wire [7:0] sub_res = sub_full[7:0];
  wire sub_ov = (wreg_r[7] ^ mval[7]) & (wreg_r[7] ^ sub_res[7]);

  reg [7:0] res;
  reg to_wreg, to_mem, upd_z, upd_c, new_c, upd_sub, two_cyc;
  always @* begin
    res = `MIE_ZERO8;
    to_wreg = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    new_c = carry_r;
    upd_sub = 1'b0;
    two_cyc = 1'b0;
    case (op)
      `MIE_OP_INVERT_TO_REGISTER_OP: begin
        res = ~mval;
        to_wreg = 1'b1;
        upd_z = 1'b1;
      end
      `MIE_OP_BCD: begin
        res = bcd_res;
        to_mem = 1'b1;
        upd_c = 1'b1;
        new_c = adj_hi;
      end
      `MIE_OP_INC, `MIE_OP_INCA: begin
        res = mval + `MIE_ONE8;
        to_mem = (op == `MIE_OP_INC);
        to_wreg = (op == `MIE_OP_INCA);
        upd_z = 1'b1;
      end
      `MIE_OP_DEC, `MIE_OP_DECA: begin
        res = mval - `MIE_ONE8;
        to_mem = (op == `MIE_OP_DEC);
        to_wreg = (op == `MIE_OP_DECA);
        upd_z = 1'b1;
      end
      `MIE_OP_JMP, `MIE_OP_RET, `MIE_OP_INTERRUPT_RETURN_OP: two_cyc = 1'b1;
      `MIE_OP_MOVAM: begin
        res = mval;
        to_wreg = 1'b1;
      end
      `MIE_OP_MOVAX: begin
        res = imm;
        to_wreg = 1'b1;
      end
      `MIE_OP_MOVMA: begin
        res = wreg_r;
        to_mem = 1'b1;
      end
      `MIE_OP_ORAM, `MIE_OP_ORM: begin
        res = wreg_r | mval;
        to_wreg = (op == `MIE_OP_ORAM);
        to_mem = (op == `MIE_OP_ORM);
        upd_z = 1'b1;
      end
      `MIE_OP_ORAX: begin
        res = wreg_r | imm;
        to_wreg = 1'b1;
        upd_z = 1'b1;
      end
      `MIE_OP_RETAX: begin
        res = imm;
        to_wreg = 1'b1;
        two_cyc = 1'b1;
      end
      `MIE_OP_RL, `MIE_OP_RLA: begin
        res = {mval[6:0], mval[7]};
        to_mem = (op == `MIE_OP_RL);
        to_wreg = (op == `MIE_OP_RLA);
      end
      `MIE_OP_RLC, `MIE_OP_RLCA: begin
        res = {mval[6:0], carry_r};
        to_mem = (op == `MIE_OP_RLC);
        to_wreg = (op == `MIE_OP_RLCA);
        upd_c = 1'b1;
        new_c = mval[7];
      end
      `MIE_OP_RR, `MIE_OP_RRA: begin
        res = {mval[0], mval[7:1]};
        to_mem = (op == `MIE_OP_RR);
        to_wreg = (op == `MIE_OP_RRA);
      end
      `MIE_OP_RRC, `MIE_OP_RRCA: begin
        res = {carry_r, mval[7:1]};
        to_mem = (op == `MIE_OP_RRC);
        to_wreg = (op == `MIE_OP_RRCA);
        upd_c = 1'b1;
        new_c = mval[0];
      end
      `MIE_OP_SUBB, `MIE_OP_SUBBM: begin
        res = sub_res;
        to_wreg = (op == `MIE_OP_SUBB);
        to_mem = (op == `MIE_OP_SUBBM);
        upd_z = 1'b1;
        upd_c = 1'b1;
        new_c = ~sub_full[8];
        upd_sub = 1'b1;
      end
      default: res = `MIE_ZERO8; // no-op and halt touch no data
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire exec = (state_r == ST_EXEC);
  wire is_ret = (op == `MIE_OP_RET) | (op == `MIE_OP_RETAX) | (op == `MIE_OP_INTERRUPT_RETURN_OP);
  wire do_halt = exec && op == `MIE_OP_HALT;
  wire wake = wr_irq && hwdata[`MIE_I_WAKE];
  assign core_clk_en = (state_r != ST_HALT);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      instr_r <= 32'h00000000;
    end else begin
      case (state_r)
        ST_IDLE: if (wr_instr) begin
          instr_r <= hwdata;
          state_r <= ST_EXEC;
        end
        // one cycle unless the program counter is reloaded
        ST_EXEC: state_r <= do_halt ? ST_HALT : (two_cyc ? ST_DUMMY : ST_IDLE);
        ST_DUMMY: state_r <= ST_IDLE;
        ST_HALT: if (wake) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // working register and flags
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wreg_r <= `MIE_ZERO8;
      carry_r <= 1'b0;
      half_carry_flag_r <= 1'b0;
      zero_r <= 1'b0;
      signed_range_flag_r <= 1'b0;
      power_down_flag_r <= 1'b0;
      global_interrupt_gate_r <= 1'b0;
    end else if (exec) begin
      if (to_wreg) wreg_r <= res;
      if (upd_z) zero_r <= (res == `MIE_ZERO8);
      if (upd_c) carry_r <= new_c;
      if (upd_sub) begin
        half_carry_flag_r <= ~sub_nib[4];
        signed_range_flag_r <= sub_ov;
      end
      if (do_halt) power_down_flag_r <= 1'b1;
      if (op == `MIE_OP_INTERRUPT_RETURN_OP) global_interrupt_gate_r <= ~irq_pend_r;
    end else begin
      if (wr_wreg) wreg_r <= hwdata[7:0];
      if (wr_stat) begin
        carry_r <= hwdata[`MIE_S_C];
        half_carry_flag_r <= hwdata[`MIE_S_AC];
        zero_r <= hwdata[`MIE_S_Z];
        signed_range_flag_r <= hwdata[`MIE_S_OV];
        global_interrupt_gate_r <= hwdata[`MIE_S_GIE];
      end
      if (wake) power_down_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // program counter, stack, pending interrupt
  // ----------------------------------------
  // a pending interrupt at interrupt return skips the pop, pushes the program counter only onto an empty stack, and enters the vector
  wire svc = exec && op == `MIE_OP_INTERRUPT_RETURN_OP && irq_pend_r;
  integer k;
  integer j;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= {PC_W{1'b0}};
      sp_r <= {(STACK_AW+1){1'b0}};
      irq_pend_r <= 1'b0;
      for (k = 0; k < STACK_DEPTH; k = k + 1)
        stack_r[k] <= {PC_W{1'b0}};
    end else begin
      if (exec) begin
        if (op == `MIE_OP_JMP)
          pc_r <= jaddr;
        else if (svc)
          pc_r <= `MIE_INT_VEC;
        else if (is_ret)
          pc_r <= stk_empty ? pc_r : stk_top;
        else if (!do_halt)
          pc_r <= pc_r + 1'b1;
        if (is_ret && !stk_empty && !svc)
          sp_r <= sp_dec;
        if (svc && stk_empty) begin
          stack_r[0] <= pc_r;
          sp_r <= {{STACK_AW{1'b0}}, 1'b1};
        end
      end else begin
        if (wr_pc) pc_r <= hwdata[PC_W-1:0];
        if (wr_push && sp_r < STACK_DEPTH) begin
          stack_r[sp_r[STACK_AW-1:0]] <= hwdata[PC_W-1:0];
          sp_r <= sp_r + 1'b1;
        end
      end
      // the service cycle consumes the request; a new raise the same cycle wins
      if (wr_irq && hwdata[`MIE_I_PEND])
        irq_pend_r <= 1'b1;
      else if (svc)
        irq_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // data memory
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (j = 0; j < MEM_DEPTH; j = j + 1)
        mem_r[j] <= `MIE_ZERO8;
    end else if (exec && to_mem) begin
      mem_r[midx] <= res;
    end else if (wr_mem) begin
      mem_r[bus_midx] <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // watchdog: frozen while halted, as the core clock is off
  // ----------------------------------------
  wire pre_wrap = (pre_r == {PRE_W{1'b1}});
  wire wd_wrap = pre_wrap && (watchdog_counter_r == {WDOG_W{1'b1}});
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= {PRE_W{1'b0}};
      watchdog_counter_r <= {WDOG_W{1'b0}};
      watchdog_timeout_flag_r <= 1'b0;
    end else if (do_halt) begin
      pre_r <= {PRE_W{1'b0}};
      watchdog_counter_r <= {WDOG_W{1'b0}};
      watchdog_timeout_flag_r <= 1'b0;
    end else if (state_r != ST_HALT) begin
      pre_r <= pre_r + 1'b1;
      if (pre_wrap) watchdog_counter_r <= watchdog_counter_r + 1'b1;
      if (wd_wrap)
        watchdog_timeout_flag_r <= 1'b1;
      else if (wr_stat && !hwdata[`MIE_S_TO])
        watchdog_timeout_flag_r <= 1'b0;
    end
  end

endmodule // mie_core

`default_nettype wire

// File: sim/mie_core_props.sv
/*
  bus timing and clock enable checker for the execute block.
  assumes hready is fed back from hreadyout and a single bus master.
*/
`include "mie_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mie_core_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic core_clk_en
);
  // ----------------------------------------
  // data phase tracking
  // ----------------------------------------
  logic dph_r;
  logic dwr_r;
  logic [9:0] dix_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r <= 1'b0;
      dwr_r <= 1'b0;
      dix_r <= 10'h000;
    end else if (hready) begin
      dph_r <= hsel & htrans[1];
      dwr_r <= hwrite;
      dix_r <= haddr[11:2];
    end
  end
  wire logic taken = hsel & htrans[1] & hready;
  wire logic wr_next = taken & hwrite;
  wire logic [4:0] opc = hwdata[4:0];
  wire logic iw_done = dph_r & dwr_r & (dix_r == 10'h000) & hready & core_clk_en;
  wire logic is_jmp = opc == `MIE_OP_JMP;
  wire logic is_ret = (opc == `MIE_OP_RET) | (opc == `MIE_OP_RETAX) | (opc == `MIE_OP_INTERRUPT_RETURN_OP);
  wire logic is_one = !is_jmp & !is_ret & (opc != `MIE_OP_HALT);
  wire logic wake_w = dph_r & dwr_r & (dix_r == 10'h005) & hready & hwdata[`MIE_I_WAKE];
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence one_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence two_wait_s;
    !hreadyout [*2] ##1 hreadyout;
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (taken && !hwrite |=> one_wait_s)
    else $error("read wait count wrong");
  write_bound_a: assert property (wr_next |=> ##[0:2] hreadyout)
    else $error("write wait too long");
  one_cycle_a: assert property (iw_done && is_one && wr_next |=> one_wait_s)
    else $error("single cycle instruction took wrong time");
  jump_two_a: assert property (iw_done && is_jmp && wr_next |=> two_wait_s)
    else $error("jump did not take two cycles");
  ret_two_a: assert property (iw_done && is_ret && wr_next |=> two_wait_s)
    else $error("return did not take two cycles");
  halt_stop_a: assert property (iw_done && opc == `MIE_OP_HALT |=> ##[0:2] !core_clk_en)
    else $error("halt left clock running");
  halt_ignore_a: assert property (dph_r && dwr_r && dix_r == 10'h000 && !core_clk_en |-> hreadyout)
    else $error("instruction ran while halted");
  wake_only_a: assert property ($rose(core_clk_en) |-> $past(wake_w) || $past(wake_w, 2))
    else $error("clock resumed without wake");
endmodule // mie_core_props

bind mie_core mie_core_props i_mie_core_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .core_clk_en(core_clk_en)
);
`default_nettype wire

// File: sim/mie_ahb_master.sv
/*
  ahb-lite single-transfer master model with wait-bounded tasks.
  assumes hready is the slave's hreadyout; answers are taken at the
  completing rising edge, before the design's updates of that edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mie_ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic hung = 1'b0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // ready and read data are taken at the rising edge that completes the phase
  task automatic wt(output logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 40) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 40) hung = 1'b1;
    d = hrdata;
  endtask
  // second write rides in the first one's data phase
  task automatic wr2(input logic [31:0] a0, input logic [31:0] d0, input logic [31:0] a1, input logic [31:0] d1);
    logic [31:0] x;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= a0;
    wt(x);
    haddr <= a1;
    hwdata <= d0;
    wt(x);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d1;
    wt(x);
    hwdata <= ~d1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr <= a;
    wt(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    wt(d);
  endtask
endmodule // mie_ahb_master
`default_nettype wire

// File: sim/mcu_instruction_execute_test.sv
/*
  self-checking bench: every opcode with random operands, compared with an
  integer model of the execute unit.
  assumes the master model drives all bus inputs of the design except hready, which is the design's own hreadyout.
*/
`include "mie_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_execute_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  wire logic hsel, hwrite, hready, hresp, core_clk_en;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic [31:0] haddr, hwdata, hrdata;
  int err_total = 0;
  int compares = 0;
  logic [31:0] lfsr = 32'h0000DB17;
  int w, c, ac, z, ov, power_down_flag, gie, pc, pend, hlt;
  int mem [16];
  int stk [$];
  always #2 hclk = ~hclk;
  mie_core i_mie_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .core_clk_en(core_clk_en));
  mie_ahb_master i_mie_ahb_master (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [31:0] st();
    return (hlt << 7) | (gie << 6) | (power_down_flag << 4) | (ov << 3) | (z << 2) | (ac << 1) | c;
  endfunction
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // unmapped second write keeps every instruction followed back to back
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_mie_ahb_master.wr2(a, d, 32'h000000FC, 32'h00000000);
    if (i_mie_ahb_master.hung) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_mie_ahb_master.rd(a, d);
    if (i_mie_ahb_master.hung) begin
      err_total++;
      end_sim();
    end
    chk(d, e);
  endtask
  task automatic exec(input int op, input int imm, input int ix, input int ad);
    int m, r, b, p;
    m = mem[ix];
    b = 1 - c;
    p = pc;
    pc = (pc + 1) & 4095;
    r = -1;
    case (op)
      1: w = ~m & 255;
      2: begin
        b = (w >> 4) > 9 || c;
        mem[ix] = (w + (((w & 15) > 9 || ac) ? 6 : 0) + (b ? 96 : 0)) & 255;
        c = b;
      end
      3, 4: mem[ix] = (op == 3 ? m + 1 : m - 1) & 255;
      5, 6: w = (op == 5 ? m + 1 : m - 1) & 255;
      7: begin
        power_down_flag = 1;
        hlt = 1;
        pc = p;
      end
      8: pc = ad;
      9: w = m;
      10: w = imm;
      11: mem[ix] = w;
      12: w = w | m;
      13: w = w | imm;
      14: mem[ix] = w | m;
      15, 16, 17: begin
        if (op == 17 && pend) begin
          pend = 0;
          if (stk.size() == 0) stk.push_back(p);
          pc = 4;
        end else begin
          pc = stk.size() ? stk.pop_back() : p;
          gie = op == 17 ? 1 : gie;
        end
        if (op == 16) w = imm;
      end
      18, 19: r = ((m << 1) | (m >> 7)) & 255;
      20, 21: begin
        r = ((m << 1) | c) & 255;
        c = m >> 7;
      end
      22, 23: r = (m >> 1) | ((m & 1) << 7);
      24, 25: begin
        r = (m >> 1) | (c << 7);
        c = m & 1;
      end
      26, 27: begin
        r = w - m - b;
        c = r >= 0;
        ac = (w & 15) - (m & 15) - b >= 0;
        r = r & 255;
        ov = (((w ^ m) & (w ^ r)) >> 7) & 1;
        z = r == 0;
      end
      default: ;
    endcase
    if (op == 1 || op == 5 || op == 6 || op == 12 || op == 13) z = w == 0;
    if (op == 3 || op == 4 || op == 14) z = mem[ix] == 0;
    if (r >= 0 && ((op < 26) ? (op % 2 == 1) : (op == 26))) w = r;
    else if (r >= 0) mem[ix] = r;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int op, ix, v;
    logic [31:0] iw, sv;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`MIE_A_STAT, 32'h00000000);
    rdc(`MIE_A_PC, 32'h00000000);
    for (int i = 0; i < 60; i++) begin
      op = i % 30;
      iw = (rnd() & 32'h0FFFFF00) | op;
      ix = iw[19:16];
      w = rnd() & 255;
      wr(`MIE_A_WREG, w);
      sv = rnd() & 32'h0000004F;
      gie = sv[6];
      ov = sv[3];
      z = sv[2];
      ac = sv[1];
      c = sv[0];
      wr(`MIE_A_STAT, sv);
      mem[ix] = rnd() & 255;
      wr(`MIE_A_MEM + 4 * ix, mem[ix]);
      v = rnd() & 4095;
      wr(`MIE_A_STACK, v);
      if (stk.size() < 8) stk.push_back(v);
      wr(`MIE_A_INSTR, iw);
      exec(op, iw[15:8], ix, iw[27:16]);
      if (op == 7) begin
        wr(`MIE_A_INSTR, 32'h0000550A);
        rdc(`MIE_A_STAT, st());
        rdc(`MIE_A_WREG, w);
        wr(`MIE_A_IRQ, 32'h00000002);
        power_down_flag = 0;
        hlt = 0;
      end
      rdc(`MIE_A_WREG, w);
      rdc(`MIE_A_STAT, st());
      rdc(`MIE_A_MEM + 4 * ix, mem[ix]);
      rdc(`MIE_A_PC, pc);
      rdc(`MIE_A_STACK, stk.size());
      $display("test %0d opcode %0d done", i, op);
    end
    // pending request at an interrupt return is taken before the pop
    wr(`MIE_A_STAT, 32'h00000000);
    {gie, ov, z, ac, c} = 0;
    wr(`MIE_A_IRQ, 32'h00000001);
    pend = 1;
    wr(`MIE_A_INSTR, 32'h00000011);
    exec(17, 0, 0, 0);
    rdc(`MIE_A_PC, pc);
    rdc(`MIE_A_STACK, stk.size());
    rdc(`MIE_A_IRQ, pend);
    wr(`MIE_A_INSTR, 32'h00000011);
    exec(17, 0, 0, 0);
    rdc(`MIE_A_STAT, st());
    rdc(`MIE_A_PC, pc);
    rdc(32'h000000FC, 32'h00000000);
    $display("test interrupt return done");
    end_sim();
  end
endmodule // mcu_instruction_execute_test
`default_nettype wire
